// ---- hdl/pcer_bank.sv ----
/*
 * Correctable error status, mask, extended CRC control, first error
 * pointer and header log, reached by configuration reads and writes.
 * Assumes error detectors and the configuration port run on CLK_SYS_I;
 * the two reset pins are asynchronous, active low, and are synchronised.
 */
`timescale 1ns/1ps
module pcer_bank
   import pcer_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic FUNDAMENTAL_LINK_RESET_N_I,
   input wire logic GLOBAL_RESET_INPUT_N_I,
   input wire logic CFG_REQ_I,
   input wire logic CFG_WR_I,
   input wire logic [11:0] CFG_ADDR_I,
   input wire logic [3:0] CFG_BE_I,
   input wire logic [31:0] CFG_WDATA_I,
   output logic CFG_ACK_O,
   output logic [31:0] CFG_RDATA_O,
   input wire pcer_cor_evt_t COR_EVT_I,
   input wire pcer_uncor_evt_t UNCOR_EVT_I,
   input wire logic UNCOR_STATUS_EMPTY_I,
   input wire logic HDR_VALID_I,
   input wire pcer_hdr_bytes_t HDR_BYTES_I,
   output logic COR_ERR_MSG_O,
   output logic END_CRC_CHECK_ON_O,
   output logic END_CRC_GENERATE_ON_O
);

   // ****************************************************************
   // Reset pins into the clock domain
   // ****************************************************************
   logic link_rst_n_s1_q;
   logic link_rst_n_s2_q;
   logic glob_rst_n_s1_q;
   logic glob_rst_n_s2_q;
   logic clr;

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         link_rst_n_s1_q <= 1'b1;
         link_rst_n_s2_q <= 1'b1;
      end else begin
         link_rst_n_s1_q <= FUNDAMENTAL_LINK_RESET_N_I;
         link_rst_n_s2_q <= link_rst_n_s1_q;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         glob_rst_n_s1_q <= 1'b1;
         glob_rst_n_s2_q <= 1'b1;
      end else begin
         glob_rst_n_s1_q <= GLOBAL_RESET_INPUT_N_I;
         glob_rst_n_s2_q <= glob_rst_n_s1_q;
      end
   end

   // Any of the three resets clears the bank
   assign clr = RST_I | ~link_rst_n_s2_q | ~glob_rst_n_s2_q;

   // ****************************************************************
   // Access decode
   // ****************************************************************
   logic [31:0] be_bits;
   logic wr_flags;
   logic wr_suppress;
   logic wr_ctrl;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         be_bits[i*8 +: 8] = {8{CFG_BE_I[i]}};
      end
   end

   assign wr_flags = CFG_REQ_I & CFG_WR_I
                     & (CFG_ADDR_I[11:2] == PCER_FLAGS_ADDR[11:2]);
   assign wr_suppress = CFG_REQ_I & CFG_WR_I
                        & (CFG_ADDR_I[11:2] == PCER_SUPPRESS_ADDR[11:2]);
   assign wr_ctrl = CFG_REQ_I & CFG_WR_I
                    & (CFG_ADDR_I[11:2] == PCER_CAPS_CTRL_ADDR[11:2]);

   // ****************************************************************
   // Error events
   // ****************************************************************
   logic [31:0] raw_evt;
   logic [31:0] set_evt;
   logic [31:0] flags_q;
   logic [31:0] flags_d;
   logic [31:0] suppress_q;
   logic [31:0] w1c;

   always_comb begin
      raw_evt = '0;
      raw_evt[PCER_RETRY_TIMER_BIT] = COR_EVT_I.retry_timer_expired;
      raw_evt[PCER_REPLAY_WRAP_BIT] = COR_EVT_I.replay_count_wrapped;
      raw_evt[PCER_LINK_PKT_BIT] = COR_EVT_I.decode_fault
                                   & COR_EVT_I.in_link_packet;
      raw_evt[PCER_TRANS_PKT_BIT] = COR_EVT_I.decode_fault
                                    & COR_EVT_I.in_transaction_packet;
      raw_evt[PCER_RX_DECODE_BIT] = COR_EVT_I.decode_fault;
   end

   // Masked errors never reach the flags
   assign set_evt = raw_evt & ~suppress_q & PCER_COR_IMPL_MASK;

   // Write one clears, within enabled lanes only
   assign w1c = wr_flags ? (CFG_WDATA_I & be_bits) : '0;

   // New event wins over a clear in the same cycle
   assign flags_d = ((flags_q & ~w1c) | set_evt)
                    & PCER_COR_IMPL_MASK;

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         flags_q <= PCER_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ****************************************************************
   // Suppress register
   // ****************************************************************
   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         suppress_q <= PCER_SUPPRESS_RST;
      end else if (wr_suppress) begin
         suppress_q <= ((suppress_q & ~be_bits)
                        | (CFG_WDATA_I & be_bits))
                       & PCER_COR_IMPL_MASK;
      end
   end

   // ****************************************************************
   // Extended CRC enables
   // ****************************************************************
   logic check_on_q;
   logic gen_on_q;

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         check_on_q <= PCER_CAPS_CTRL_RST[PCER_CHECK_ON_BIT];
         gen_on_q <= PCER_CAPS_CTRL_RST[PCER_GEN_ON_BIT];
      end else if (wr_ctrl) begin
         if (CFG_BE_I[PCER_CHECK_ON_BIT/8]) begin
            check_on_q <= CFG_WDATA_I[PCER_CHECK_ON_BIT];
         end
         if (CFG_BE_I[PCER_GEN_ON_BIT/8]) begin
            gen_on_q <= CFG_WDATA_I[PCER_GEN_ON_BIT];
         end
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         END_CRC_CHECK_ON_O <= 1'b0;
      end else begin
         END_CRC_CHECK_ON_O <= check_on_q;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         END_CRC_GENERATE_ON_O <= 1'b0;
      end else begin
         END_CRC_GENERATE_ON_O <= gen_on_q;
      end
   end

   // ****************************************************************
   // First error pointer
   // ****************************************************************
   logic [PCER_FIRST_IDX_W-1:0] first_idx_q;

   // Loads only on the first uncorrectable error, never from writes
   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         first_idx_q <= PCER_FIRST_IDX_RST;
      end else if (UNCOR_EVT_I.valid && UNCOR_STATUS_EMPTY_I) begin
         first_idx_q <= UNCOR_EVT_I.status_index;
      end
   end

   // ****************************************************************
   // Header log
   // ****************************************************************
   logic [31:0] hdr_q [PCER_HDR_WORDS];
   logic log_en;

   // Only unmasked errors load the log
   assign log_en = HDR_VALID_I & ((|set_evt) | UNCOR_EVT_I.valid);

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         for (int w = 0; w < PCER_HDR_WORDS; w++) begin
            hdr_q[w] <= PCER_HDR_RST;
         end
      end else if (log_en) begin
         for (int w = 0; w < PCER_HDR_WORDS; w++) begin
            // Earliest byte into lane 0
            hdr_q[w] <= {HDR_BYTES_I[w*4+3], HDR_BYTES_I[w*4+2],
                         HDR_BYTES_I[w*4+1],
                         HDR_BYTES_I[w*4]};
         end
      end
   end

   // ****************************************************************
   // Error message
   // ****************************************************************
   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         COR_ERR_MSG_O <= 1'b0;
      end else begin
         COR_ERR_MSG_O <= |set_evt;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   logic [31:0] caps_ctrl;
   logic [31:0] rd_data;

   always_comb begin
      caps_ctrl = '0;
      caps_ctrl[PCER_CHECK_ON_BIT] = check_on_q;
      caps_ctrl[PCER_CHECK_SUP_BIT] = 1'b1;
      caps_ctrl[PCER_GEN_ON_BIT] = gen_on_q;
      caps_ctrl[PCER_GEN_SUP_BIT] = 1'b1;
      caps_ctrl[PCER_FIRST_IDX_W-1:0] = first_idx_q;
   end

   always_comb begin
      unique case (CFG_ADDR_I[11:2])
         PCER_FLAGS_ADDR[11:2]: rd_data = flags_q;
         PCER_SUPPRESS_ADDR[11:2]: rd_data = suppress_q;
         PCER_CAPS_CTRL_ADDR[11:2]: rd_data = caps_ctrl;
         PCER_HDR_WORD0_ADDR[11:2]: rd_data = hdr_q[0];
         PCER_HDR_WORD1_ADDR[11:2]: rd_data = hdr_q[1];
         PCER_HDR_WORD2_ADDR[11:2]: rd_data = hdr_q[2];
         PCER_HDR_WORD3_ADDR[11:2]: rd_data = hdr_q[3];
         default: rd_data = PCER_UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         CFG_ACK_O <= 1'b0;
      end else begin
         CFG_ACK_O <= CFG_REQ_I;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         CFG_RDATA_O <= PCER_UNMAPPED_DATA;
      end else if (CFG_REQ_I && !CFG_WR_I) begin
         CFG_RDATA_O <= rd_data;
      end
   end

endmodule

// ---- hdl/pcer_pkg.sv ----
/*
 * Constants and carrier types for the correctable error reporting bank.
 * Assumes a 32-bit configuration data path and byte addresses of 12 bits.
 */
package pcer_pkg;

   // ****************************************************************
   // Register map (byte addresses in extended configuration space)
   // ****************************************************************
   localparam logic [11:0] PCER_FLAGS_ADDR = 12'h110;
   localparam logic [11:0] PCER_SUPPRESS_ADDR = 12'h114;
   localparam logic [11:0] PCER_CAPS_CTRL_ADDR = 12'h118;
   localparam logic [11:0] PCER_HDR_WORD0_ADDR = 12'h11c;
   localparam logic [11:0] PCER_HDR_WORD1_ADDR = 12'h120;
   localparam logic [11:0] PCER_HDR_WORD2_ADDR = 12'h124;
   localparam logic [11:0] PCER_HDR_WORD3_ADDR = 12'h128;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int PCER_RETRY_TIMER_BIT = 12;
   localparam int PCER_REPLAY_WRAP_BIT = 8;
   localparam int PCER_LINK_PKT_BIT = 7;
   localparam int PCER_TRANS_PKT_BIT = 6;
   localparam int PCER_RX_DECODE_BIT = 0;
   localparam int PCER_CHECK_ON_BIT = 8;
   localparam int PCER_CHECK_SUP_BIT = 7;
   localparam int PCER_GEN_ON_BIT = 6;
   localparam int PCER_GEN_SUP_BIT = 5;
   localparam int PCER_FIRST_IDX_W = 5;

   // Implemented status and mask bits; all others read zero
   localparam logic [31:0] PCER_COR_IMPL_MASK = 32'h0000_11c1;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [31:0] PCER_FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] PCER_SUPPRESS_RST = 32'h0000_0000;
   localparam logic [31:0] PCER_CAPS_CTRL_RST = 32'h0000_00a0;
   localparam logic [31:0] PCER_HDR_RST = 32'h0000_0000;
   localparam logic [4:0] PCER_FIRST_IDX_RST = 5'h00;
   localparam logic [31:0] PCER_UNMAPPED_DATA = 32'h0000_0000;

   // Uncorrectable data link protocol error position
   localparam logic [4:0] PCER_DLL_PROTO_IDX = 5'h04;

   localparam int PCER_HDR_WORDS = 4;
   localparam int PCER_HDR_BYTES = 16;

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic retry_timer_expired;
      logic replay_count_wrapped;
      logic decode_fault;
      logic in_link_packet;
      logic in_transaction_packet;
   } pcer_cor_evt_t;

   typedef struct packed {
      logic valid;
      logic [4:0] status_index;
   } pcer_uncor_evt_t;

   // Header bytes, index 0 = earliest transmitted on the link
   typedef logic [PCER_HDR_BYTES-1:0][7:0] pcer_hdr_bytes_t;

endpackage

// ---- verification/pcer_bank_properties.sv ----
/* Checker on the bank ports: config port, events and CRC enables.
   Assumes no request or event while a reset pin is held low. */
`timescale 1ns/1ps
module pcer_bank_properties
   import pcer_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic CFG_REQ_I,
   input wire logic CFG_WR_I,
   input wire logic [11:0] CFG_ADDR_I,
   input wire logic [31:0] CFG_WDATA_I,
   input wire logic [3:0] CFG_BE_I,
   input wire logic CFG_ACK_O,
   input wire logic [31:0] CFG_RDATA_O,
   input wire pcer_cor_evt_t COR_EVT_I,
   input wire logic COR_ERR_MSG_O,
   input wire logic END_CRC_CHECK_ON_O,
   input wire logic END_CRC_GENERATE_ON_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   logic sup_rx_q;
   wire logic rd_req = CFG_REQ_I && !CFG_WR_I;
   wire logic ctl_wr = CFG_REQ_I && CFG_WR_I &&
      CFG_ADDR_I == PCER_CAPS_CTRL_ADDR;
   // Receiver error suppress bit, followed from writes
   always_ff @(posedge CLK_SYS_I)
      if (RST_I)
         sup_rx_q <= 1'b0;
      else if (CFG_REQ_I && CFG_WR_I && CFG_BE_I[0] &&
         CFG_ADDR_I == PCER_SUPPRESS_ADDR)
         sup_rx_q <= CFG_WDATA_I[0];
   sequence open_fault;
      COR_EVT_I.decode_fault && !sup_rx_q;
   endsequence
   sequence flags_read;
      rd_req && CFG_ADDR_I == PCER_FLAGS_ADDR;
   endsequence
   rsvd_read_zero_a: assert property (
      rd_req && (CFG_ADDR_I & 12'hff8) == PCER_FLAGS_ADDR
      |=> CFG_ACK_O && (CFG_RDATA_O & ~PCER_COR_IMPL_MASK) == 32'h0)
      else $error("reserved bits read nonzero");
   caps_read_one_a: assert property (
      rd_req && CFG_ADDR_I == PCER_CAPS_CTRL_ADDR
      |=> CFG_RDATA_O[7] && CFG_RDATA_O[5] && CFG_RDATA_O[31:9] == 23'h0)
      else $error("capability bits wrong");
   check_follow_a: assert property (
      ctl_wr && CFG_BE_I[1]
      |-> ##2 END_CRC_CHECK_ON_O == $past(CFG_WDATA_I[8], 2))
      else $error("check enable not following write");
   gen_follow_a: assert property (
      ctl_wr && CFG_BE_I[0]
      |-> ##2 END_CRC_GENERATE_ON_O == $past(CFG_WDATA_I[6], 2))
      else $error("generate enable not following write");
   msg_when_open_a: assert property (
      open_fault |=> COR_ERR_MSG_O)
      else $error("no message for open error");
   msg_when_shut_a: assert property (
      COR_EVT_I == 5'h04 && sup_rx_q |=> !COR_ERR_MSG_O)
      else $error("message for suppressed error");
   msg_has_cause_a: assert property (
      COR_ERR_MSG_O |-> ($past(COR_EVT_I) & 5'h1c) != 5'h00)
      else $error("message without event");
   flag_seen_a: assert property (
      open_fault ##1 flags_read |=> CFG_RDATA_O[0])
      else $error("receiver error flag missing");
   ack_follows_req_a: assert property (
      CFG_ACK_O == $past(CFG_REQ_I))
      else $error("acknowledge not one cycle after request");
endmodule
bind pcer_bank pcer_bank_properties chk (.CLK_SYS_I(CLK_SYS_I),
   .RST_I(RST_I), .CFG_REQ_I(CFG_REQ_I), .CFG_WR_I(CFG_WR_I),
   .CFG_ADDR_I(CFG_ADDR_I), .CFG_WDATA_I(CFG_WDATA_I),
   .CFG_BE_I(CFG_BE_I), .CFG_ACK_O(CFG_ACK_O), .CFG_RDATA_O(CFG_RDATA_O),
   .COR_EVT_I(COR_EVT_I), .COR_ERR_MSG_O(COR_ERR_MSG_O),
   .END_CRC_CHECK_ON_O(END_CRC_CHECK_ON_O),
   .END_CRC_GENERATE_ON_O(END_CRC_GENERATE_ON_O));

// ---- verification/pcer_host.sv ----
/* Upstream host model issuing configuration reads and writes.
   Assumes the bank acknowledges one cycle after each request. */
`timescale 1ns/1ps
module pcer_host (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] rdata_i,
   output logic req_o,
   output logic wr_o,
   output logic [11:0] addr_o,
   output logic [3:0] be_o,
   output logic [31:0] wdata_o
);
   initial {req_o, wr_o, addr_o, be_o, wdata_o} = '0;
   // Called just past a rising edge; request is a one-cycle pulse
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [3:0] b, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      req_o <= 1'b1;
      {wr_o, addr_o, be_o, wdata_o} <= {w, a, b, d};
      @(posedge clk_i);
      req_o <= 1'b0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 4);
      q = (ack_i === 1'b1) ? rdata_i : 'x;
      // Released lines carry no stale value
      addr_o <= ~a;
      wdata_o <= ~d;
      // One idle edge so the next call never reassigns these lines at once
      @(posedge clk_i);
   endtask
endmodule

// ---- verification/tb_pcer_bank.sv ----
/* Bench for the correctable error bank, driven through the host model.
   Assumes the property checker is bound to the bank. */
`timescale 1ns/1ps
module tb_pcer_bank
   import pcer_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, flr_n = 1'b1, global_reset_input_n = 1'b1;
   logic req, wr, ack, hv = 1'b0, empty = 1'b1, msg, c_on, g_on;
   logic [11:0] addr;
   logic [3:0] be;
   logic [31:0] wd, rd, q;
   pcer_cor_evt_t evt = 5'h00;
   pcer_uncor_evt_t uev = 6'h00;
   pcer_hdr_bytes_t hb;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   pcer_bank dut (.CLK_SYS_I(clk), .RST_I(rst),
      .FUNDAMENTAL_LINK_RESET_N_I(flr_n), .GLOBAL_RESET_INPUT_N_I(global_reset_input_n),
      .CFG_REQ_I(req), .CFG_WR_I(wr), .CFG_ADDR_I(addr), .CFG_BE_I(be),
      .CFG_WDATA_I(wd), .CFG_ACK_O(ack), .CFG_RDATA_O(rd),
      .COR_EVT_I(evt), .UNCOR_EVT_I(uev), .UNCOR_STATUS_EMPTY_I(empty),
      .HDR_VALID_I(hv), .HDR_BYTES_I(hb), .COR_ERR_MSG_O(msg),
      .END_CRC_CHECK_ON_O(c_on), .END_CRC_GENERATE_ON_O(g_on));
   pcer_host host (.clk_i(clk), .ack_i(ack), .rdata_i(rd), .req_o(req),
      .wr_o(wr), .addr_o(addr), .be_o(be), .wdata_o(wd));
   initial forever #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, 4'hf, d, q);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 4'h0, 32'h0, q);
      chk(q, e);
   endtask
   task automatic fire(input pcer_cor_evt_t e);
      evt <= e;
      hv <= 1'b1;
      @(posedge clk);
      evt <= 5'h00;
      hv <= 1'b0;
   endtask
   task automatic t_reset_vals;
      logic [31:0] e;
      chk({30'h0, c_on, g_on}, 32'h0);
      for (int i = 0; i < 7; i++) begin
         e = (i == 2) ? 32'h0000_00a0 : 32'h0;
         rdc(PCER_FLAGS_ADDR + 12'(4 * i), e);
      end
      rdc(12'h100, 32'h0);
      $display("reset values done");
   endtask
   task automatic t_events;
      pcer_cor_evt_t ev [5] = '{5'h10, 5'h08, 5'h06, 5'h05, 5'h04};
      logic [31:0] fl [5] = '{32'h1000, 32'h0100, 32'h0081, 32'h0041, 32'h1};
      for (int i = 0; i < 5; i++) begin
         fire(ev[i]);
         rdc(PCER_FLAGS_ADDR, fl[i]);
         wr32(PCER_FLAGS_ADDR, 32'h0);
         rdc(PCER_FLAGS_ADDR, fl[i]);
         wr32(PCER_FLAGS_ADDR, fl[i]);
         rdc(PCER_FLAGS_ADDR, 32'h0);
      end
      rdc(PCER_HDR_WORD0_ADDR, 32'h4342_4140);
      rdc(PCER_HDR_WORD1_ADDR, 32'h4746_4544);
      rdc(PCER_HDR_WORD2_ADDR, 32'h4b4a_4948);
      rdc(PCER_HDR_WORD3_ADDR, 32'h4f4e_4d4c);
      $display("events done");
   endtask
   task automatic t_mask;
      host.xfer(1'b1, PCER_SUPPRESS_ADDR, 4'h1, 32'hffff_ffff, q);
      rdc(PCER_SUPPRESS_ADDR, 32'h0000_00c1);
      wr32(PCER_SUPPRESS_ADDR, 32'hffff_ffff);
      rdc(PCER_SUPPRESS_ADDR, 32'h0000_11c1);
      hb[0] <= 8'h99;
      fire(5'h1f);
      fire(5'h04);
      rdc(PCER_FLAGS_ADDR, 32'h0);
      rdc(PCER_HDR_WORD0_ADDR, 32'h4342_4140);
      wr32(PCER_SUPPRESS_ADDR, 32'h0);
      hb[0] <= 8'h77;
      fire(5'h04);
      rdc(PCER_HDR_WORD0_ADDR, 32'h4342_4177);
      hb[0] <= 8'h40;
      $display("mask done");
   endtask
   task automatic t_ctrl;
      wr32(PCER_CAPS_CTRL_ADDR, 32'hffff_ffff);
      rdc(PCER_CAPS_CTRL_ADDR, 32'h0000_01e0);
      chk({30'h0, c_on, g_on}, 32'h3);
      wr32(PCER_CAPS_CTRL_ADDR, 32'h0);
      rdc(PCER_CAPS_CTRL_ADDR, 32'h0000_00a0);
      chk({30'h0, c_on, g_on}, 32'h0);
      $display("control done");
   endtask
   task automatic t_ptr;
      uev <= {1'b1, PCER_DLL_PROTO_IDX};
      hv <= 1'b1;
      hb[1] <= 8'h55;
      @(posedge clk);
      empty <= 1'b0;
      uev <= 6'h27;
      hv <= 1'b0;
      hb[1] <= 8'h41;
      @(posedge clk);
      uev <= 6'h00;
      wr32(PCER_CAPS_CTRL_ADDR, 32'h0000_001f);
      rdc(PCER_CAPS_CTRL_ADDR, 32'h0000_00a4);
      rdc(PCER_HDR_WORD0_ADDR, 32'h4342_5540);
      empty <= 1'b1;
      $display("pointer done");
   endtask
   task automatic t_race;
      fire(5'h04);
      fork
         wr32(PCER_FLAGS_ADDR, 32'h1);
         fire(5'h04);
      join
      rdc(PCER_FLAGS_ADDR, 32'h1);
      $display("race done");
   endtask
   task automatic t_pin_reset;
      for (int p = 0; p < 2; p++) begin
         fire(5'h04);
         wr32(PCER_CAPS_CTRL_ADDR, 32'h0000_0140);
         flr_n <= (p != 0);
         global_reset_input_n <= (p == 0);
         repeat (4) @(posedge clk);
         flr_n <= 1'b1;
         global_reset_input_n <= 1'b1;
         repeat (4) @(posedge clk);
         t_reset_vals;
      end
      $display("pin reset done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 16; i++)
         hb[i] = 8'h40 + 8'(i);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset_vals;
      t_events;
      t_mask;
      t_ctrl;
      t_ptr;
      t_race;
      t_pin_reset;
      print_verdict;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         $display("unexpected at %0t: run hung", $time);
         print_verdict;
      end
   end
endmodule
